// ===== verilog/adc_result_port.sv
/*
 Result coding, status flags, sync gating and two-pin port, APB slave.
 Assumes the modulator pulses rawValid per result and refLow is a level.
*/
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/100ps

module adc_result_port #(
    parameter int RAW_W = 20
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire adc_port_pkg::apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rawValid,
    input wire logic signed [RAW_W-1:0] rawResult,
    input wire logic refLow,
    output logic convRun,
    output logic calUpdate,
    output logic port0Out,
    output logic port0AnalogSel,
    output logic port1Out,
    output logic port1OeN,
    input wire logic port1In,
    output logic irq
);
    import adc_port_pkg::*;

    state_t state_r, state_nxt;
    coded_t coded;
    logic [`MODE_W-1:0] mode_r, mode_nxt;
    logic [`IO_W-1:0] io_r, io_nxt;
    logic [`EV_W-1:0] irqStat_r, irqStat_nxt, mask_r, evt;
    logic [`DATA_W-1:0] data_r;
    logic sign_r, over_r, missing_reference_flag_r, missing_reference_flag_nxt, ready_r, ready_nxt;
    logic holdLow_r, holdLow_nxt;
    logic [31:0] prdata_r, readMux;
    logic pready_r, pslverr_r, convRun_r, calUpdate_r, irq_r;
    logic port0Out_r, port0AnalogSel_r, port1Out_r, port1OeN_r;

    wire apbAccess = apbReq.psel && apbReq.penable;
    wire apbDone = apbAccess && pready_r;
    wire wrEn = apbDone && apbReq.pwrite;
    wire rdEn = apbDone && !apbReq.pwrite;
    wire selMode = apbReq.paddr == `OFS_MODE;
    wire selIo = apbReq.paddr == `OFS_IOPORT;
    wire selCh = apbReq.paddr == `OFS_CHSTAT;
    wire selData = apbReq.paddr == `OFS_DATA;
    wire selIrq = apbReq.paddr == `OFS_IRQSTAT;
    wire selMask = apbReq.paddr == `OFS_IRQMASK;
    wire selConv = apbReq.paddr == `OFS_CONVSTAT;
    wire unmapped = !(selMode | selIo | selCh | selData | selIrq | selMask | selConv);

    wire [2:0] wrModeCode = apbReq.pwdata[2:0];
    wire wrModeLegal = wrModeCode <= `MODE_CAL_LAST;
    wire wrMode = wrEn && selMode;
    wire startReq = wrMode && wrModeLegal && wrModeCode != `MODE_IDLE;
    wire stopReq = wrMode && !startReq;
    wire [2:0] modeCode = mode_r[2:0];
    wire isCal = modeCode >= `MODE_CAL_FIRST && modeCode <= `MODE_CAL_LAST;
    wire isSingle = modeCode == `MODE_SINGLE;
    wire clampOn = mode_r[`MODE_CLAMP_BIT];
    wire bipolarOn = mode_r[`MODE_BIPOLAR_BIT];
    wire syncEn = io_r[`IO_SYNC_EN_BIT];
    // The far end keeps the sync line at a valid level, so it is used unfiltered
    wire syncBlock = syncEn && !port1In;
    wire running = state_r == ST_RUN;
    wire resLatch = running && rawValid && !isCal;
    wire calFinish = running && rawValid && isCal;
    wire opDone = calFinish || (resLatch && isSingle);

    result_coder #(
        .RAW_W(RAW_W)
    ) coder (
        .raw(rawResult),
        .bipolar(bipolarOn),
        .clamp(clampOn),
        .coded(coded)
    );

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (startReq) begin
                    state_nxt = syncBlock ? ST_SYNC_WAIT : ST_RUN;
                end
            end
            ST_SYNC_WAIT: begin
                if (stopReq) begin
                    state_nxt = ST_IDLE;
                end else if (!syncBlock) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stopReq || opDone) begin
                    state_nxt = ST_IDLE;
                end else if (syncBlock) begin
                    state_nxt = ST_SYNC_WAIT;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Finished single and calibration runs fall back to idle mode
    assign mode_nxt = wrMode ? (wrModeLegal ? apbReq.pwdata[`MODE_W-1:0] :
        {apbReq.pwdata[`MODE_W-1:3], `MODE_IDLE}) :
        opDone ? {mode_r[`MODE_W-1:3], `MODE_IDLE} : mode_r;
    assign io_nxt = (wrEn && selIo) ? apbReq.pwdata[`IO_W-1:0] : io_r;

    // Flag is rearmed at each new run, but an event the same cycle wins
    wire runEntry = state_nxt == ST_RUN && !running;
    assign missing_reference_flag_nxt = (missing_reference_flag_r && !runEntry) || (running && refLow);
    assign ready_nxt = (ready_r && !(rdEn && selData)) || resLatch || calFinish;
    // Calibration end pulls the sync line low until the port is rewritten
    assign holdLow_nxt = calFinish || (holdLow_r && !(wrEn && selIo));

    assign evt[`EV_CONV_BIT] = resLatch;
    assign evt[`EV_CAL_BIT] = calFinish;
    assign evt[`EV_MISSING_REFERENCE_FLAG_BIT] = running && refLow && !missing_reference_flag_r;
    assign evt[`EV_OVR_BIT] = resLatch && coded.over;
    // Set wins over a write-one clear in the same cycle
    assign irqStat_nxt = (irqStat_r & ~((wrEn && selIrq) ?
        apbReq.pwdata[`EV_W-1:0] : `MASK_RST)) | evt;

    assign readMux = selMode ? {27'h0000000, mode_r} :
        selIo ? {26'h0000000, port1In, io_r} :
        selCh ? {28'h0000000, missing_reference_flag_r, over_r, sign_r, ready_r} :
        selData ? {16'h0000, data_r} :
        selIrq ? {28'h0000000, irqStat_r} :
        selMask ? {28'h0000000, mask_r} :
        selConv ? {28'h0000000, ready_r, state_r} : 32'h00000000;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else if (clkEn) begin
            pready_r <= apbAccess && !pready_r;
            pslverr_r <= apbAccess && !pready_r && unmapped;
            prdata_r <= (apbAccess && !pready_r) ? readMux : prdata_r;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            mode_r <= `MODE_RST;
            io_r <= `IO_RST;
            mask_r <= `MASK_RST;
            irqStat_r <= `MASK_RST;
        end else if (clkEn) begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            io_r <= io_nxt;
            mask_r <= (wrEn && selMask) ? apbReq.pwdata[`EV_W-1:0] : mask_r;
            irqStat_r <= irqStat_nxt;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_r <= `DATA_ZERO;
            sign_r <= 1'b0;
            over_r <= 1'b0;
            missing_reference_flag_r <= 1'b0;
            ready_r <= 1'b0;
            holdLow_r <= 1'b0;
        end else if (clkEn) begin
            if (resLatch) begin
                data_r <= coded.data;
                sign_r <= coded.sign;
                over_r <= coded.over;
            end
            missing_reference_flag_r <= missing_reference_flag_nxt;
            ready_r <= ready_nxt;
            holdLow_r <= holdLow_nxt;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            convRun_r <= 1'b0;
            calUpdate_r <= 1'b0;
            irq_r <= 1'b0;
            port0Out_r <= 1'b0;
            port0AnalogSel_r <= 1'b0;
            port1Out_r <= 1'b0;
            port1OeN_r <= 1'b1;
        end else if (clkEn) begin
            convRun_r <= state_nxt == ST_RUN;
            calUpdate_r <= calFinish;
            irq_r <= |(irqStat_nxt & mask_r);
            port0Out_r <= io_nxt[`IO_P0_VAL_BIT];
            port0AnalogSel_r <= io_nxt[`IO_P0_ANALOG_BIT];
            port1Out_r <= !io_nxt[`IO_SYNC_EN_BIT] && io_nxt[`IO_P1_VAL_BIT];
            port1OeN_r <= io_nxt[`IO_SYNC_EN_BIT] ? !holdLow_nxt :
                !io_nxt[`IO_P1_DRIVE_BIT];
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign convRun = convRun_r;
    assign calUpdate = calUpdate_r;
    assign irq = irq_r;
    assign port0Out = port0Out_r;
    assign port0AnalogSel = port0AnalogSel_r;
    assign port1Out = port1Out_r;
    assign port1OeN = port1OeN_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    clamp_high_a: assert property (clkEn && resLatch && clampOn && coded.over && !coded.sign
        |=> data_r == `DATA_ONES) else $error("clamp above range not all ones");
    clamp_low_a: assert property (clkEn && resLatch && clampOn && coded.over && coded.sign
        |=> data_r == `DATA_ZERO) else $error("clamp below range not all zeros");
    bipolar_wrap_a: assert property (clkEn && resLatch && !clampOn && bipolarOn
        |=> data_r == ($past(rawResult[`DATA_W-1:0]) ^ `CODE_MID))
        else $error("bipolar code not offset wrap of raw");
    ovr_flag_a: assert property (clkEn && resLatch && bipolarOn
        |=> over_r == ($past(rawResult) > $signed(RAW_W'(16'h7FFF))
        || $past(rawResult) < -$signed(RAW_W'(`CODE_MID))))
        else $error("bipolar overrange flag wrong");
    uni_negative_a: assert property (clkEn && resLatch && !bipolarOn && rawResult < 0
        |=> data_r == `DATA_ZERO && sign_r && over_r) else $error("unipolar negative code wrong");
    missing_reference_flag_set_a: assert property (clkEn && running && refLow
        |=> missing_reference_flag_r) else $error("missing reference not flagged");
    sync_hold_a: assert property (clkEn && syncEn && !port1In
        |=> !convRun_r && state_r != ST_RUN) else $error("conversion ran with sync low");
    sync_start_a: assert property (clkEn && state_r == ST_SYNC_WAIT && port1In && !stopReq
        |=> state_r == ST_RUN ##0 convRun_r) else $error("no start on sync high");
    cal_done_a: assert property (clkEn && calFinish && syncEn
        |=> state_r == ST_IDLE && calUpdate_r && ready_r && !port1OeN_r && !port1Out_r)
        else $error("calibration end sequence wrong");

    clamp_seen_c: cover property (clkEn && resLatch && clampOn && coded.over);
    wrap_seen_c: cover property (clkEn && resLatch && !clampOn && coded.over);
    sync_wait_c: cover property (state_r == ST_SYNC_WAIT ##[1:20] state_r == ST_RUN);
    cal_end_c: cover property (clkEn && calFinish);
endmodule

// ===== verilog/adc_port_params.svh
/*
 Register offsets, field positions, codes and reset values of the
 result and port block. Assumes inclusion by both the package and the bench.
*/
`ifndef ADC_PORT_PARAMS_SVH
`define ADC_PORT_PARAMS_SVH

`define OFS_MODE 8'h00
`define OFS_IOPORT 8'h04
`define OFS_CHSTAT 8'h08
`define OFS_DATA 8'h0C
`define OFS_IRQSTAT 8'h10
`define OFS_IRQMASK 8'h14
`define OFS_CONVSTAT 8'h18

`define MODE_W 5
`define MODE_IDLE 3'h0
`define MODE_SINGLE 3'h1
`define MODE_CONT 3'h2
`define MODE_CAL_FIRST 3'h3
`define MODE_CAL_LAST 3'h6
`define MODE_CLAMP_BIT 3
`define MODE_BIPOLAR_BIT 4
`define MODE_RST 5'h00

`define IO_W 5
`define IO_P0_VAL_BIT 0
`define IO_P0_ANALOG_BIT 1
`define IO_P1_VAL_BIT 2
`define IO_P1_DRIVE_BIT 3
`define IO_SYNC_EN_BIT 4
`define IO_RST 5'h00

`define EV_W 4
`define EV_CONV_BIT 0
`define EV_CAL_BIT 1
`define EV_MISSING_REFERENCE_FLAG_BIT 2
`define EV_OVR_BIT 3
`define MASK_RST 4'h0

`define DATA_W 16
`define CODE_MID 16'h8000
`define DATA_ONES 16'hFFFF
`define DATA_ZERO 16'h0000

`endif

// ===== verilog/adc_port_pkg.sv
/*
 Types shared by the result and port block.
 Assumes the constants header is on the include path.
*/
`include "adc_port_params.svh"

package adc_port_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [`DATA_W-1:0] data;
        logic sign;
        logic over;
    } coded_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SYNC_WAIT = 3'b010,
        ST_RUN = 3'b100
    } state_t;

endpackage

// ===== verilog/result_coder.sv
/*
 Turns a signed raw result into the output code, sign and overrange.
 Assumes raw counts are scaled so one count is one output LSB.
*/
`timescale 1ns/100ps

module result_coder #(
    parameter int RAW_W = 20
) (
    input wire logic signed [RAW_W-1:0] raw,
    input wire logic bipolar,
    input wire logic clamp,
    output adc_port_pkg::coded_t coded
);
    import adc_port_pkg::*;

    logic signed [RAW_W-1:0] shifted;
    logic signed [RAW_W-1:0] fsMax;
    logic above;
    logic below;

    // Bipolar codes are offset binary around mid scale
    assign shifted = bipolar ? raw + $signed(RAW_W'(`CODE_MID)) : raw;
    assign fsMax = $signed(RAW_W'(`DATA_ONES));
    // Overrange comes from the digital result only
    assign above = shifted > fsMax;
    assign below = shifted < 0;
    assign coded.sign = raw[RAW_W-1];
    assign coded.over = above | below;
    // Unless clamping, low bits of an out-of-range value give the wrap codes, except a unipolar value below zero, which gives zero
    assign coded.data = (clamp && above) ? `DATA_ONES :
        (clamp && below) ? `DATA_ZERO :
        (!bipolar && below) ? `DATA_ZERO :
        shifted[`DATA_W-1:0];
endmodule

// ===== sim/sync_partner.sv
/*
 Far-side model of the external sync logic that shares pin one.
 Assumes the block's pin one drive value and active low enable as inputs.
*/
`timescale 1ns/100ps

module sync_partner (
    input wire logic syncLevel,
    input wire logic port1Out,
    input wire logic port1OeN,
    output logic pinLevel
);
    // The far side always holds a defined level, so the pin never floats
    assign pinLevel = (port1OeN === 1'b0) ? port1Out : syncLevel;
endmodule

// ===== sim/adc_result_port_test.sv
/*
 Self-checking bench for the result and port block: APB master, result pulses.
 Assumes the constants header and the package are compiled before this file.
*/
`timescale 1ns/100ps
`include "adc_port_params.svh"
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin miscompares++; $display("wrong value at %0t: got %h want %h", $time, a, b); end end

module adc_result_port_test;
    import adc_port_pkg::*;
    localparam int RW = 20;
    logic clk = 0, reset_n = 0, clkEn = 1, rawValid = 0, refLow = 0, syncLevel = 0;
    logic signed [RW-1:0] rawResult = '0;
    apb_req_t req = '0;
    logic [31:0] prdata;
    logic pready, pslverr, convRun, calUpdate, port0Out, port0AnalogSel;
    logic port1Out, port1OeN, pinLevel, irq, calSeen;
    logic [32:0] expQ[$];
    int miscompares = 0, testsRun = 0, cycles = 0, seed = 95194, r;
    // Columns: mode word, raw count, data word, channel status
    int tab[17][4] = '{'{32'h12, 0, 32'h8000, 1}, '{32'h12, 32767, 32'hFFFF, 1},
        '{32'h12, 32768, 32'h0, 5}, '{32'h12, 32769, 32'h1, 5}, '{32'h12, -1, 32'h7FFF, 3},
        '{32'h12, -32768, 32'h0, 3}, '{32'h12, -32769, 32'hFFFF, 7},
        '{32'h12, -32770, 32'hFFFE, 7}, '{32'h2, 0, 32'h0, 1}, '{32'h2, 65535, 32'hFFFF, 1},
        '{32'h2, 65536, 32'h0, 5}, '{32'h2, 65537, 32'h1, 5}, '{32'h2, -1, 32'h0, 7},
        '{32'h1A, 32768, 32'hFFFF, 5}, '{32'h1A, -32769, 32'h0, 7},
        '{32'h1A, 100, 32'h8064, 1}, '{32'h0A, 65536, 32'hFFFF, 5}};

    adc_result_port #(.RAW_W(RW)) i_adc_result_port (.clk(clk), .reset_n(reset_n),
        .clkEn(clkEn), .apbReq(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rawValid(rawValid), .rawResult(rawResult), .refLow(refLow), .convRun(convRun),
        .calUpdate(calUpdate), .port0Out(port0Out), .port0AnalogSel(port0AnalogSel),
        .port1Out(port1Out), .port1OeN(port1OeN), .port1In(pinLevel), .irq(irq));
    sync_partner i_sync_partner (.syncLevel(syncLevel), .port1Out(port1Out),
        .port1OeN(port1OeN), .pinLevel(pinLevel));

    initial begin
        forever #20 clk = ~clk;
    end

    task final_report;
        $display("comparisons %0d, mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Master holds the request until the edge that samples pready high
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b0, wr, a, d};
        if (!wr) expQ.push_back(e);
        @(posedge clk);
        req.penable <= 1'b1;
        @(negedge clk);
        while (pready !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n == 40) miscompares++;
        @(posedge clk);
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        bus(1'b0, a, 32'h0, e);
    endtask

    task automatic pulse(input int v);
        @(posedge clk);
        rawValid <= 1'b1;
        rawResult <= v[RW-1:0];
        @(posedge clk);
        rawValid <= 1'b0;
    endtask

    task automatic waitRun(input logic v);
        int n;
        n = 0;
        while (convRun !== v && n < 40) begin
            @(negedge clk);
            n++;
        end
        `CHK(convRun, v)
    endtask

    // Read results are compared against the oldest note when pready shows
    always @(posedge clk) begin
        cycles++;
        if (calUpdate === 1'b1) calSeen = 1'b1;
        if (pready === 1'b1 && req.penable && !req.pwrite && expQ.size() > 0) begin
            `CHK({pslverr, prdata}, expQ.pop_front())
        end
        if (cycles == 5000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        calSeen = 1'b0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        rd(`OFS_CONVSTAT, 33'h1);
        rd(`OFS_IRQMASK, 33'h0);
        rd(8'h1C, {1'b1, 32'h0});
        rd(8'h02, {1'b1, 32'h0});
        for (int i = 0; i < 17; i++) begin
            wr(`OFS_MODE, tab[i][0]);
            waitRun(1'b1);
            pulse(tab[i][1]);
            rd(`OFS_CHSTAT, {29'h0, tab[i][3][3:0]});
            rd(`OFS_DATA, {17'h0, tab[i][2][15:0]});
        end
        // The last table row leaves unipolar clamping on; random codes expect bipolar
        wr(`OFS_MODE, 32'h12);
        for (int i = 0; i < 6; i++) begin
            r = $random(seed) % 32768;
            pulse(r);
            rd(`OFS_CHSTAT, (r < 0) ? 33'h3 : 33'h1);
            rd(`OFS_DATA, {17'h0, 16'(r + 32768)});
        end
        `CHK(irq, 1'b0)
        wr(`OFS_MODE, 32'h12);
        refLow <= 1'b1;
        pulse(5);
        refLow <= 1'b0;
        rd(`OFS_CHSTAT, 33'h9);
        rd(`OFS_DATA, 33'h8005);
        wr(`OFS_IRQMASK, 32'h4);
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b1)
        wr(`OFS_IRQSTAT, 32'hF);
        wr(`OFS_MODE, 32'h0);
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b0)
        wr(`OFS_IOPORT, 32'h10);
        wr(`OFS_MODE, 32'h1);
        pulse(7);
        `CHK(convRun, 1'b0)
        rd(`OFS_CONVSTAT, 33'h2);
        syncLevel <= 1'b1;
        waitRun(1'b1);
        pulse(-5);
        waitRun(1'b0);
        rd(`OFS_CHSTAT, 33'h7);
        rd(`OFS_DATA, 33'h0);
        // Sync stays enabled so calibration end pulls the sync line low
        for (int m = 3; m <= 6; m++) begin
            wr(`OFS_IOPORT, 32'h10);
            calSeen = 1'b0;
            wr(`OFS_MODE, m);
            waitRun(1'b1);
            pulse(0);
            waitRun(1'b0);
            // Let the monitor see the one-cycle calibration pulse first
            @(negedge clk);
            `CHK({calSeen, port1OeN, port1Out}, 3'b100)
            rd(`OFS_CONVSTAT, 33'h9);
        end
        wr(`OFS_IOPORT, 32'h0F);
        repeat (2) @(negedge clk);
        `CHK({port0Out, port0AnalogSel, port1OeN, port1Out}, 4'b1101)
        rd(`OFS_IOPORT, 33'h2F);
        syncLevel <= 1'b0;
        wr(`OFS_IOPORT, 32'h03);
        rd(`OFS_IOPORT, 33'h03);
        `CHK(port1OeN, 1'b1)
        final_report();
    end
endmodule
